// ===== ulfmc_pkg.sv
package ulfmc_pkg;
    // Register indices on the plain register port (byte addresses)
    localparam logic [3:0] ADDR_DATA = 4'h0;
    localparam logic [3:0] ADDR_ISR = 4'h2;
    localparam logic [3:0] ADDR_FCR = 4'h2;
    localparam logic [3:0] ADDR_LCR = 4'h3;
    localparam logic [3:0] ADDR_MCR = 4'h4;
    localparam logic [3:0] ADDR_STAT = 4'h8;
    localparam logic [3:0] ADDR_EFR = 4'h9;
    localparam logic [3:0] ADDR_FEATURE_CONTROL_REG = 4'hA;
    localparam logic [3:0] ADDR_TRG = 4'hB;
    localparam logic [3:0] ADDR_GPIO_IRQ_ENABLE_REG = 4'hC;
    localparam logic [3:0] ADDR_FIFOLVL = 4'hD;
    localparam logic [3:0] ADDR_DIVL = 4'hE;
    localparam logic [3:0] ADDR_DIVM = 4'hF;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // fifo_control fields
    localparam int FC_EN = 0;
    localparam int FC_RXRST = 1;
    localparam int FC_TXRST = 2;
    localparam int FC_WAKE = 3;
    localparam int FC_TXT_LO = 4;
    localparam int FC_RXT_LO = 6;
    // line_control fields
    localparam int LC_BRK = 6;
    localparam int LC_DLAB = 7;
    localparam int LC_PEN = 3;
    localparam int LC_EPS = 4;
    localparam int LC_STICK = 5;
    localparam int LC_STB = 2;
    // modem_control fields
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_GPSEL = 2;
    localparam int MC_OUT2 = 3;
    localparam int MC_LOOP = 4;
    localparam int MC_ANY = 5;
    localparam int MC_IR = 6;
    localparam int MC_PRESC = 7;
    localparam int EFR_ENH = 4;
    localparam int FEATURE_CONTROL_REG_TBL_LO = 4;
    localparam int FEATURE_CONTROL_REG_TRG_TX = 7;
    localparam logic [1:0] PRESC_DIV4 = 2'h3;
    typedef enum logic [1:0] {
        ULFMC_TBL_A = 2'b00,
        ULFMC_TBL_B = 2'b01,
        ULFMC_TBL_C = 2'b10,
        ULFMC_TBL_D = 2'b11
    } ulfmc_tbl_t;
    typedef enum logic [1:0] {
        ULFMC_STOP_1 = 2'b00,
        ULFMC_STOP_1H = 2'b01,
        ULFMC_STOP_2 = 2'b10
    } ulfmc_stop_t;
    typedef enum logic [2:0] {
        ULFMC_PAR_NONE = 3'b000,
        ULFMC_PAR_ODD = 3'b001,
        ULFMC_PAR_EVEN = 3'b010,
        ULFMC_PAR_MARK = 3'b011,
        ULFMC_PAR_SPACE = 3'b100
    } ulfmc_par_t;
endpackage

// ===== ulfmc_ctrl.sv
`timescale 1ns/1ps
module ulfmc_ctrl
    import ulfmc_pkg::*;
#(
    parameter int LVL_W = 8
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [LVL_W-1:0] rx_count,
    input wire logic [LVL_W-1:0] tx_count,
    input wire logic tx_reload,
    input wire logic gpio_irq_pending,
    input wire logic rx_char_valid,
    input wire logic rx_char_is_flow,
    input wire logic sw_flow_active,
    input wire logic tx_ser_raw,
    input wire logic tx_ser_ir,
    output logic tx_serial,
    output logic rx_fifo_reset,
    output logic tx_fifo_reset,
    output logic rx_store,
    output logic tx_resume,
    output logic rx_irq,
    output logic tx_irq,
    output logic wake_irq_en,
    output logic [LVL_W-1:0] rx_trigger,
    output logic [LVL_W-1:0] tx_trigger,
    output logic [1:0] word_len,
    output ulfmc_stop_t stop_mode,
    output ulfmc_par_t parity_mode,
    output logic dtr_n_out,
    output logic rts_n_out,
    output logic gpio_mode,
    output logic loop_en,
    output logic loop_ring,
    output logic loop_aux_two_n,
    output logic ir_en,
    output logic [1:0] presc_div_m1,
    output logic [15:0] baud_divisor
);
    ////////////////////////////////////////////////////////////////////
    logic rst_s1_q;
    logic rst_n_q;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    logic [7:0] fcr_q;
    logic [7:0] lcr_q;
    logic [7:0] mcr_q;
    logic [7:0] efr_q;
    logic [7:0] feature_control_reg_q;
    logic [7:0] trg_rx_q;
    logic [7:0] trg_tx_q;
    logic [7:0] gpio_irq_enable_reg_q;
    logic [7:0] divl_q;
    logic [7:0] divm_q;
    logic [1:0] tbl_q;
    logic wr_fcr;
    logic enh;
    assign enh = efr_q[EFR_ENH];
    assign wr_fcr = reg_wr && reg_addr == ADDR_FCR;

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            fcr_q <= RESET_BYTE;
        end else if (wr_fcr) begin
            fcr_q[FC_EN] <= reg_wdata[FC_EN];
            if (reg_wdata[FC_EN]) begin
                fcr_q[7:6] <= reg_wdata[7:6];
                if (enh) begin
                    fcr_q[FC_WAKE] <= reg_wdata[FC_WAKE];
                    fcr_q[5:4] <= reg_wdata[5:4];
                end
            end
        end
    end

    // Table choice comes only from the feature control register; fifo_control never sets it
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tbl_q <= ULFMC_TBL_A;
        end else if (reg_wr && reg_addr == ADDR_FEATURE_CONTROL_REG) begin
            tbl_q <= reg_wdata[FEATURE_CONTROL_REG_TBL_LO +: 2];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rx_fifo_reset <= 1'b0;
            tx_fifo_reset <= 1'b0;
        end else begin
            // One-cycle pulse, so the control bit reads back cleared
            rx_fifo_reset <= wr_fcr && reg_wdata[FC_EN] && reg_wdata[FC_RXRST];
            tx_fifo_reset <= wr_fcr && reg_wdata[FC_EN] && reg_wdata[FC_TXRST];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lcr_q <= RESET_BYTE;
            mcr_q <= RESET_BYTE;
            efr_q <= RESET_BYTE;
            feature_control_reg_q <= RESET_BYTE;
            trg_rx_q <= RESET_BYTE;
            trg_tx_q <= RESET_BYTE;
            gpio_irq_enable_reg_q <= RESET_BYTE;
            divl_q <= RESET_BYTE;
            divm_q <= RESET_BYTE;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_LCR: lcr_q <= reg_wdata;
                ADDR_MCR: begin
                    mcr_q[4:0] <= reg_wdata[4:0];
                    // Enhanced-only bits hold their value without the gate
                    if (enh) begin
                        mcr_q[7:5] <= reg_wdata[7:5];
                    end
                end
                ADDR_EFR: efr_q <= reg_wdata;
                ADDR_FEATURE_CONTROL_REG: feature_control_reg_q <= reg_wdata;
                ADDR_TRG: begin
                    if (feature_control_reg_q[FEATURE_CONTROL_REG_TRG_TX]) begin
                        trg_tx_q <= reg_wdata;
                    end else begin
                        trg_rx_q <= reg_wdata;
                    end
                end
                ADDR_GPIO_IRQ_ENABLE_REG: gpio_irq_enable_reg_q <= reg_wdata;
                // Direct divisor access, independent of the line control mapping
                ADDR_DIVL: divl_q <= reg_wdata;
                ADDR_DIVM: divm_q <= reg_wdata;
                ADDR_DATA: begin
                    if (lcr_q[LC_DLAB]) begin
                        divl_q <= reg_wdata;
                    end
                end
                ADDR_DATA + 4'h1: begin
                    if (lcr_q[LC_DLAB]) begin
                        divm_q <= reg_wdata;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Trigger levels
    logic [7:0] rx_lvl;
    logic [7:0] tx_lvl;
    always_comb begin
        rx_lvl = 8'h01;
        tx_lvl = 8'h01;
        case (tbl_q)
            ULFMC_TBL_A: begin
                case (fcr_q[FC_RXT_LO +: 2])
                    2'h0: rx_lvl = 8'h01;
                    2'h1: rx_lvl = 8'h04;
                    2'h2: rx_lvl = 8'h08;
                    default: rx_lvl = 8'h0E;
                endcase
                tx_lvl = 8'h01;
            end
            ULFMC_TBL_B: begin
                case (fcr_q[FC_RXT_LO +: 2])
                    2'h0: rx_lvl = 8'h08;
                    2'h1: rx_lvl = 8'h10;
                    2'h2: rx_lvl = 8'h18;
                    default: rx_lvl = 8'h1C;
                endcase
                case (fcr_q[FC_TXT_LO +: 2])
                    2'h0: tx_lvl = 8'h10;
                    2'h1: tx_lvl = 8'h08;
                    2'h2: tx_lvl = 8'h18;
                    default: tx_lvl = 8'h1E;
                endcase
            end
            ULFMC_TBL_C: begin
                case (fcr_q[FC_RXT_LO +: 2])
                    2'h0: rx_lvl = 8'h08;
                    2'h1: rx_lvl = 8'h10;
                    2'h2: rx_lvl = 8'h38;
                    default: rx_lvl = 8'h3C;
                endcase
                case (fcr_q[FC_TXT_LO +: 2])
                    2'h0: tx_lvl = 8'h08;
                    2'h1: tx_lvl = 8'h10;
                    2'h2: tx_lvl = 8'h20;
                    default: tx_lvl = 8'h38;
                endcase
            end
            default: begin
                rx_lvl = trg_rx_q;
                tx_lvl = trg_tx_q;
            end
        endcase
    end

    // Transmit trigger arms only once a reload pushes the count above it
    logic tx_filled_q;
    logic [LVL_W-1:0] tx_prev_q;
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rx_trigger <= '0;
            tx_trigger <= '0;
            rx_irq <= 1'b0;
            tx_irq <= 1'b0;
            tx_filled_q <= 1'b0;
            tx_prev_q <= '0;
        end else begin
            rx_trigger <= LVL_W'(rx_lvl);
            tx_trigger <= LVL_W'(tx_lvl);
            tx_prev_q <= tx_count;
            rx_irq <= fcr_q[FC_EN] && rx_count >= LVL_W'(rx_lvl);
            if (tx_reload) begin
                tx_filled_q <= tx_count > LVL_W'(tx_lvl);
            end
            tx_irq <= fcr_q[FC_EN] && ((tx_filled_q && tx_count < LVL_W'(tx_lvl)
                && tx_prev_q >= LVL_W'(tx_lvl))
                || (!tx_filled_q && tx_count == '0));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Line and modem outputs
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            word_len <= 2'h0;
            stop_mode <= ULFMC_STOP_1;
            parity_mode <= ULFMC_PAR_NONE;
            tx_serial <= 1'b1;
            dtr_n_out <= 1'b1;
            rts_n_out <= 1'b1;
            gpio_mode <= 1'b0;
            loop_en <= 1'b0;
            loop_ring <= 1'b0;
            loop_aux_two_n <= 1'b1;
            ir_en <= 1'b0;
            presc_div_m1 <= 2'h0;
            baud_divisor <= 16'h0000;
            wake_irq_en <= 1'b0;
        end else begin
            word_len <= lcr_q[1:0];
            if (!lcr_q[LC_STB]) begin
                stop_mode <= ULFMC_STOP_1;
            end else if (lcr_q[1:0] == 2'h0) begin
                stop_mode <= ULFMC_STOP_1H;
            end else begin
                stop_mode <= ULFMC_STOP_2;
            end
            if (!lcr_q[LC_PEN]) begin
                parity_mode <= ULFMC_PAR_NONE;
            end else if (lcr_q[LC_STICK]) begin
                parity_mode <= lcr_q[LC_EPS] ? ULFMC_PAR_SPACE : ULFMC_PAR_MARK;
            end else begin
                parity_mode <= lcr_q[LC_EPS] ? ULFMC_PAR_EVEN : ULFMC_PAR_ODD;
            end
            if (lcr_q[LC_BRK]) begin
                tx_serial <= 1'b0;
            end else begin
                tx_serial <= mcr_q[MC_IR] ? tx_ser_ir : tx_ser_raw;
            end
            dtr_n_out <= !mcr_q[MC_DTR];
            rts_n_out <= !mcr_q[MC_RTS];
            gpio_mode <= mcr_q[MC_GPSEL] && !mcr_q[MC_LOOP];
            loop_ring <= mcr_q[MC_GPSEL] && mcr_q[MC_LOOP];
            loop_en <= mcr_q[MC_LOOP];
            loop_aux_two_n <= !mcr_q[MC_OUT2];
            ir_en <= mcr_q[MC_IR];
            presc_div_m1 <= mcr_q[MC_PRESC] ? PRESC_DIV4 : 2'h0;
            baud_divisor <= {divm_q, divl_q};
            wake_irq_en <= fcr_q[FC_WAKE];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            tx_resume <= 1'b0;
            rx_store <= 1'b0;
        end else begin
            tx_resume <= mcr_q[MC_ANY] && rx_char_valid;
            rx_store <= rx_char_valid && !(rx_char_is_flow && sw_flow_active);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read port
    logic isr7;
    logic isr6;
    assign isr7 = fcr_q[FC_EN];
    assign isr6 = isr7 ^ (gpio_irq_pending && |gpio_irq_enable_reg_q);

    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reg_rdata <= RESET_BYTE;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_ISR: reg_rdata <= {isr7, isr6, 6'h01};
                ADDR_LCR: reg_rdata <= lcr_q;
                ADDR_MCR: reg_rdata <= mcr_q;
                ADDR_STAT: reg_rdata <= {tx_irq, rx_irq, tbl_q, fcr_q[FC_WAKE], 3'h0};
                ADDR_EFR: reg_rdata <= efr_q;
                ADDR_FEATURE_CONTROL_REG: reg_rdata <= feature_control_reg_q;
                ADDR_GPIO_IRQ_ENABLE_REG: reg_rdata <= gpio_irq_enable_reg_q;
                ADDR_FIFOLVL: reg_rdata <= 8'(rx_count);
                ADDR_DIVL: reg_rdata <= divl_q;
                ADDR_DIVM: reg_rdata <= divm_q;
                default: reg_rdata <= RESET_BYTE;
            endcase
        end else begin
            reg_rdata <= RESET_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    AST_ISR7: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        reg_rd && reg_addr == ADDR_ISR |=> reg_rdata[7] == $past(fcr_q[FC_EN]))
        else $error("status bit 7 does not follow FIFO enable");
    AST_ISR6: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        reg_rd && reg_addr == ADDR_ISR && !gpio_irq_pending
        |=> reg_rdata[6] == reg_rdata[7])
        else $error("status bit 6 differs from bit 7 with no GPIO event");
    AST_FEN: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        wr_fcr && !reg_wdata[FC_EN] |=> fcr_q == {$past(fcr_q[7:1]), 1'b0})
        else $error("FIFO control bits changed while enable written low");
    AST_RST1: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        rx_fifo_reset |=> !rx_fifo_reset || $past(wr_fcr, 1))
        else $error("receive FIFO reset did not self-clear");
    AST_WAKE: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        wr_fcr && !enh |=> $stable(fcr_q[FC_WAKE]))
        else $error("wake enable changed without enhanced enable");
    AST_BRK: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        lcr_q[LC_BRK] |=> !tx_serial)
        else $error("break did not hold serial output low");
    AST_DTR: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        ##1 dtr_n_out == !$past(mcr_q[MC_DTR]))
        else $error("terminal-ready output not inverted from control");
    AST_STOP: assert property (@(posedge core_clk) disable iff (!rst_n_q)
        lcr_q[LC_STB] && lcr_q[1:0] == 2'h0 |=> stop_mode == ULFMC_STOP_1H)
        else $error("5-bit words did not get one and a half stops");
endmodule

// ===== ulfmc_remote.sv
`timescale 1ns/1ps
// Far-end sender: one character strobe per request, promptly or after a gap
module ulfmc_remote (
    input wire logic core_clk,
    input wire logic send,
    input wire logic flow,
    input wire logic slow,
    output logic rx_char_valid,
    output logic rx_char_is_flow
);
    logic [2:0] wait_q;
    logic busy_q;
    logic flow_q;
    initial begin
        wait_q = 3'h0;
        busy_q = 1'b0;
        flow_q = 1'b0;
        rx_char_valid = 1'b0;
    end
    always @(posedge core_clk) begin
        rx_char_valid <= 1'b0;
        if (send) begin
            busy_q <= 1'b1;
            flow_q <= flow;
            wait_q <= slow ? 3'h5 : 3'h0;
        end else if (busy_q && wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
        end else if (busy_q) begin
            busy_q <= 1'b0;
            rx_char_valid <= 1'b1;
        end
    end
    // Qualifier only means something beside the strobe, so it shows the opposite otherwise
    assign rx_char_is_flow = rx_char_valid ? flow_q : ~flow_q;
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
    import ulfmc_pkg::*;
    logic core_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, rx_count = 8'h00, tx_count = 8'h00;
    logic tx_reload = 1'b0, gpio_irq_pending = 1'b0, sw_flow_active = 1'b0;
    logic tx_ser_raw = 1'b1, tx_ser_ir = 1'b0, send = 1'b0, flow = 1'b0, slow = 1'b0;
    logic rx_char_valid, rx_char_is_flow, tx_serial, rx_fifo_reset, tx_fifo_reset;
    logic rx_store, tx_resume, rx_irq, tx_irq, wake_irq_en, dtr_n_out, rts_n_out;
    logic gpio_mode, loop_en, loop_ring, loop_aux_two_n, ir_en;
    logic [7:0] rx_trigger, tx_trigger;
    logic [1:0] word_len, presc_div_m1;
    logic [15:0] baud_divisor;
    ulfmc_stop_t stop_mode;
    ulfmc_par_t parity_mode;
    int error_cnt = 0, n_tests = 0;
    int pc[5] = '{0, 0, 0, 0, 0};
    int s[5];
    int rxt[3][4] = '{'{1, 4, 8, 14}, '{8, 16, 24, 28}, '{8, 16, 56, 60}};
    int txt[3][4] = '{'{1, 1, 1, 1}, '{16, 8, 24, 30}, '{8, 16, 32, 56}};
    always #5 core_clk = ~core_clk;
    ulfmc_ctrl i_dut (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_count(rx_count), .tx_count(tx_count), .tx_reload(tx_reload),
        .gpio_irq_pending(gpio_irq_pending), .rx_char_valid(rx_char_valid),
        .rx_char_is_flow(rx_char_is_flow), .sw_flow_active(sw_flow_active),
        .tx_ser_raw(tx_ser_raw), .tx_ser_ir(tx_ser_ir), .tx_serial(tx_serial),
        .rx_fifo_reset(rx_fifo_reset), .tx_fifo_reset(tx_fifo_reset), .rx_store(rx_store),
        .tx_resume(tx_resume), .rx_irq(rx_irq), .tx_irq(tx_irq), .wake_irq_en(wake_irq_en),
        .rx_trigger(rx_trigger), .tx_trigger(tx_trigger), .word_len(word_len),
        .stop_mode(stop_mode), .parity_mode(parity_mode), .dtr_n_out(dtr_n_out),
        .rts_n_out(rts_n_out), .gpio_mode(gpio_mode), .loop_en(loop_en),
        .loop_ring(loop_ring), .loop_aux_two_n(loop_aux_two_n), .ir_en(ir_en),
        .presc_div_m1(presc_div_m1), .baud_divisor(baud_divisor));
    ulfmc_remote i_remote (.core_clk(core_clk), .send(send), .flow(flow), .slow(slow),
        .rx_char_valid(rx_char_valid), .rx_char_is_flow(rx_char_is_flow));
    // Pulse tallies let a check see one-cycle outputs without sampling races
    always @(posedge core_clk) begin
        pc[0] <= pc[0] + int'(rx_fifo_reset);
        pc[1] <= pc[1] + int'(tx_fifo_reset);
        pc[2] <= pc[2] + int'(rx_store);
        pc[3] <= pc[3] + int'(tx_resume);
        pc[4] <= pc[4] + int'(tx_irq);
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic settle(int n = 3);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    function automatic int dl(int k);
        return pc[k] - s[k];
    endfunction
    function automatic logic [8:0] mv();
        return {dtr_n_out, rts_n_out, gpio_mode, loop_en, loop_ring, loop_aux_two_n,
            ir_en, presc_div_m1};
    endfunction
    task automatic snd(logic f, logic sl);
        @(posedge core_clk);
        send <= 1'b1;
        flow <= f;
        slow <= sl;
        @(posedge core_clk);
        send <= 1'b0;
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] d;
        chk("modem pins", 9'h188, mv());
        chk("tx_serial", 1, tx_serial);
        chk("word_len", 0, word_len);
        rd(ADDR_ISR, d);
        chk("isr", 8'h01, d);
        rd(ADDR_LCR, d);
        chk("lcr", 8'h00, d);
        rd(4'h5, d);
        chk("unmapped", 8'h00, d);
        $display("test reset done");
    endtask
    task automatic t_isr();
        logic [7:0] d;
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_FCR, {7'h00, i[2]});
            wr(ADDR_GPIO_IRQ_ENABLE_REG, {7'h00, i[1]});
            gpio_irq_pending <= i[0];
            settle();
            rd(ADDR_ISR, d);
            chk("isr", {i[2], i[2] ^ (i[1] & i[0]), 6'h01}, d);
        end
        @(posedge core_clk);
        gpio_irq_pending <= 1'b0;
        $display("test status done");
    endtask
    task automatic t_fcr();
        logic [7:0] d;
        wr(ADDR_EFR, 8'h10);
        s = pc;
        wr(ADDR_FCR, 8'h0E);
        settle(4);
        chk("resets refused", 0, 16'(dl(0) + dl(1)));
        chk("wake refused", 0, wake_irq_en);
        s = pc;
        wr(ADDR_FCR, 8'h0F);
        settle(4);
        chk("rx reset", 1, 16'(dl(0)));
        chk("tx reset", 1, 16'(dl(1)));
        chk("wake", 1, wake_irq_en);
        wr(ADDR_EFR, 8'h00);
        wr(ADDR_FCR, 8'h01);
        settle();
        chk("wake locked", 1, wake_irq_en);
        wr(ADDR_EFR, 8'h10);
        wr(ADDR_FCR, 8'h01);
        settle();
        chk("wake off", 0, wake_irq_en);
        $display("test fifo control done");
    endtask
    task automatic t_trig();
        for (int t = 0; t < 3; t++) begin
            wr(ADDR_FEATURE_CONTROL_REG, 8'(t << 4));
            for (int i = 0; i < 4; i++) begin
                wr(ADDR_FCR, {i[1:0], i[1:0], 4'h1});
                settle();
                chk("rx trig", 16'(rxt[t][i]), rx_trigger);
                chk("tx trig", 16'(txt[t][i]), tx_trigger);
            end
        end
        wr(ADDR_FEATURE_CONTROL_REG, 8'h30);
        wr(ADDR_TRG, 8'h20);
        wr(ADDR_FEATURE_CONTROL_REG, 8'hB0);
        wr(ADDR_TRG, 8'h18);
        wr(ADDR_FCR, 8'hF1);
        settle();
        chk("rx trg reg", 8'h20, rx_trigger);
        chk("tx trg reg", 8'h18, tx_trigger);
        $display("test trigger done");
    endtask
    task automatic t_irq();
        logic [7:0] d;
        wr(ADDR_FEATURE_CONTROL_REG, 8'h00);
        wr(ADDR_FCR, 8'h41);
        rx_count <= 8'h03;
        settle();
        chk("rx irq below", 0, rx_irq);
        @(posedge core_clk);
        rx_count <= 8'h04;
        settle();
        chk("rx irq at", 1, rx_irq);
        rd(ADDR_FIFOLVL, d);
        chk("fifo level", 8'h04, d);
        rd(ADDR_STAT, d);
        chk("status", 8'hC0, d);
        wr(ADDR_FEATURE_CONTROL_REG, 8'h10);
        wr(ADDR_FCR, 8'h01);
        tx_count <= 8'h14;
        tx_reload <= 1'b1;
        @(posedge core_clk);
        tx_reload <= 1'b0;
        settle();
        s = pc;
        @(posedge core_clk);
        tx_count <= 8'h0A;
        settle(5);
        chk("tx irq fall", 1, 16'(dl(4) != 0));
        @(posedge core_clk);
        tx_count <= 8'h05;
        tx_reload <= 1'b1;
        @(posedge core_clk);
        tx_reload <= 1'b0;
        tx_count <= 8'h03;
        settle(5);
        chk("tx irq short", 0, tx_irq);
        @(posedge core_clk);
        tx_count <= 8'h00;
        settle();
        chk("tx irq empty", 1, tx_irq);
        $display("test irq done");
    endtask
    task automatic t_lcr();
        for (int w = 0; w < 4; w++) begin
            wr(ADDR_LCR, {6'h01, w[1:0]});
            settle();
            chk("word_len", 16'(w), word_len);
            chk("stop", (w == 0) ? ULFMC_STOP_1H : ULFMC_STOP_2, stop_mode);
        end
        for (int p = 0; p < 5; p++) begin
            wr(ADDR_LCR, (p == 0) ? 8'h00 : 8'(8'h08 + ((p - 1) << 4)));
            settle();
            chk("parity", 16'(p), parity_mode);
            chk("stop one", ULFMC_STOP_1, stop_mode);
        end
        wr(ADDR_LCR, 8'h40);
        settle();
        chk("break", 0, tx_serial);
        wr(ADDR_LCR, 8'hC0);
        wr(ADDR_DATA, 8'h34);
        wr(4'h1, 8'h12);
        settle();
        chk("divisor", 16'h1234, baud_divisor);
        chk("break held", 0, tx_serial);
        wr(ADDR_LCR, 8'h00);
        wr(ADDR_DIVL, 8'h78);
        wr(ADDR_DIVM, 8'h56);
        settle();
        chk("divisor", 16'h5678, baud_divisor);
        chk("no break", 1, tx_serial);
        $display("test line control done");
    endtask
    task automatic t_mcr();
        logic [7:0] d;
        wr(ADDR_EFR, 8'h00);
        wr(ADDR_MCR, 8'hFF);
        settle();
        chk("modem locked", 9'h030, mv());
        rd(ADDR_MCR, d);
        chk("mcr", 8'h1F, d);
        wr(ADDR_EFR, 8'h10);
        wr(ADDR_MCR, 8'hFF);
        settle();
        chk("modem all", 9'h037, mv());
        chk("ir out", 0, tx_serial);
        wr(ADDR_MCR, 8'h04);
        settle();
        chk("gpio only", 9'h1C8, mv());
        wr(ADDR_MCR, 8'h00);
        settle();
        chk("modem none", 9'h188, mv());
        $display("test modem control done");
    endtask
    task automatic t_any();
        wr(ADDR_MCR, 8'h20);
        sw_flow_active <= 1'b1;
        s = pc;
        snd(1'b0, 1'b0);
        settle(4);
        chk("resume", 1, 16'(dl(3)));
        chk("store", 1, 16'(dl(2)));
        s = pc;
        snd(1'b1, 1'b1);
        settle(10);
        chk("resume flow", 1, 16'(dl(3)));
        chk("store flow", 0, 16'(dl(2)));
        $display("test resume done");
    endtask
    initial begin
        #100000;
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        settle();
        t_reset();
        t_isr();
        t_fcr();
        t_trig();
        t_irq();
        t_lcr();
        t_mcr();
        t_any();
        summarize();
    end
endmodule
